/* File: shared/fcs_cfg.svh */
// offsets, bit positions, command codes and reset values of the flash command unit
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_OFS_STATUS 8'h00
`define FCS_OFS_COMMAND 8'h01
`define FCS_OFS_ADDR_HI 8'h02
`define FCS_OFS_ADDR_LO 8'h03
`define FCS_OFS_DATA 8'h04
`define FCS_OFS_IRQ_STAT 8'h05
`define FCS_OFS_IRQ_MASK 8'h06
`define FCS_BIT_CBEF 7
`define FCS_BIT_CCF 6
`define FCS_BIT_PVIOL 5
`define FCS_BIT_ACCERR 4
`define FCS_BIT_BLANK 2
`define FCS_IRQ_CCF 0
`define FCS_IRQ_PVIOL 1
`define FCS_IRQ_ACCERR 2
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_BYTE_PROG 8'h20
`define FCS_CMD_BURST_PROG 8'h25
`define FCS_CMD_PAGE_ERASE 8'h40
`define FCS_CMD_FULL_ERASE 8'h41
`define FCS_PAGE_LSB 9
`define FCS_RST_CMD 8'h00
`define FCS_RST_ADDR 16'h0000
`define FCS_RST_DATA 8'h00
`define FCS_RST_IRQ_MASK 3'h0
`endif

/* File: shared/fcs_pkg.sv */
// types of the flash command unit
`default_nettype none
package fcs_pkg;
    typedef logic [7:0] fcs_byte_t;
    typedef logic [15:0] fcs_addr_t;
    typedef logic [2:0] fcs_irq_t;
    typedef enum logic [1:0] {
        FCS_SEQ_IDLE,
        FCS_SEQ_DATA,
        FCS_SEQ_CMD
    } fcs_seq_e;
endpackage
`default_nettype wire

/* File: core/fcs_unit.sv */
// status and command front end of the flash controller
//
// How it works
// - status bits 3, 1 and 0 read zero and ignore writes
// - writing one to the buffer-empty flag launches the pending command
// - buffer-empty clears on launch write and sets again when a burst enters the array
// - only burst program is buffered; flag set means room for another
// - command-complete sets when buffer empty and nothing being processed
// - launch clears command-complete; writes to it do nothing
// - launched erase/program hitting a protected block is dropped, violation flag set
// - protection-violation clears only on a software write of one
// - broken command write sequence sets access error and drops the command
// - access error also on program/erase before divider set, or stop while busy
// - access error clears on write of one; zero write ignored
// - blank check end sets blank flag if whole array read erased
// - valid launch clears blank flag; writes to it ignored
// - codes 0x05 blank check, 0x20 byte program, 0x25 burst program
// - code 0x40 erases one 512-byte page, 0x41 the whole array
// - any other code is illegal and raises access error
//
// The plain strobed port and the placing of the registers were decided locally.
`include "fcs_cfg.svh"
`default_nettype none
module fcs_unit (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire fcs_pkg::fcs_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output fcs_pkg::fcs_byte_t o_rdata,
    input wire logic i_div_init,
    input wire logic i_prot_en,
    input wire fcs_pkg::fcs_addr_t i_prot_base,
    input wire logic i_stop_entry,
    input wire logic i_arr_done,
    input wire logic i_arr_blank,
    output logic o_arr_start,
    output fcs_pkg::fcs_byte_t o_arr_cmd,
    output fcs_pkg::fcs_addr_t o_arr_addr,
    output fcs_pkg::fcs_byte_t o_arr_data,
    output logic o_arr_abort,
    output logic o_irq
);
    import fcs_pkg::*;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic is_legal(input fcs_byte_t c);
        is_legal = (c == `FCS_CMD_BLANK) || (c == `FCS_CMD_BYTE_PROG) ||
            (c == `FCS_CMD_BURST_PROG) || (c == `FCS_CMD_PAGE_ERASE) ||
            (c == `FCS_CMD_FULL_ERASE);
    endfunction

    function automatic logic is_burst(input fcs_byte_t c);
        is_burst = (c == `FCS_CMD_BURST_PROG);
    endfunction

    function automatic logic is_modify(input fcs_byte_t c);
        is_modify = (c != `FCS_CMD_BLANK);
    endfunction

    // status byte, reserved positions held at zero
    function automatic fcs_byte_t status_byte(input logic cbef, input logic ccf,
        input logic pviol, input logic accerr, input logic blank);
        fcs_byte_t s;
        s = 8'h00;
        s[`FCS_BIT_CBEF] = cbef;
        s[`FCS_BIT_CCF] = ccf;
        s[`FCS_BIT_PVIOL] = pviol;
        s[`FCS_BIT_ACCERR] = accerr;
        s[`FCS_BIT_BLANK] = blank;
        status_byte = s;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    fcs_seq_e seq_r;
    fcs_byte_t cmd_r;
    fcs_addr_t addr_r;
    fcs_byte_t data_r;
    logic cbef_r;
    logic ccf_r;
    logic pviol_r;
    logic accerr_r;
    logic blank_r;
    logic busy_r;
    logic busy_burst_r;
    logic busy_blank_r;
    logic pend_r;
    fcs_byte_t pend_cmd_r;
    fcs_addr_t pend_addr_r;
    fcs_byte_t pend_data_r;
    fcs_irq_t irq_stat_r;
    fcs_irq_t irq_mask_r;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic wr_stat;
    logic wr_cmd;
    logic wr_addr_hi;
    logic wr_addr_lo;
    logic wr_data;
    logic wr_arr;
    logic clr_pviol;
    logic clr_accerr;
    logic launch_req;
    logic seq_err;
    logic prot_hit;
    logic launch_ok;
    logic transfer;
    logic stop_abort;
    fcs_addr_t page_end;

    assign wr_stat = i_wr && (i_addr == `FCS_OFS_STATUS);
    assign wr_cmd = i_wr && (i_addr == `FCS_OFS_COMMAND);
    assign wr_addr_hi = i_wr && (i_addr == `FCS_OFS_ADDR_HI);
    assign wr_addr_lo = i_wr && (i_addr == `FCS_OFS_ADDR_LO);
    assign wr_data = i_wr && (i_addr == `FCS_OFS_DATA);
    assign wr_arr = wr_addr_hi || wr_addr_lo || wr_data;
    assign clr_pviol = wr_stat && i_wdata[`FCS_BIT_PVIOL];
    assign clr_accerr = wr_stat && i_wdata[`FCS_BIT_ACCERR];
    assign launch_req = wr_stat && i_wdata[`FCS_BIT_CBEF];
    assign page_end = {addr_r[15:`FCS_PAGE_LSB], 9'h1FF};

    // protected when any touched location lies at or above the protection base
    always_comb begin
        prot_hit = 1'b0;
        if (i_prot_en) begin
            unique case (cmd_r)
                `FCS_CMD_FULL_ERASE: prot_hit = 1'b1;
                `FCS_CMD_PAGE_ERASE: prot_hit = (page_end >= i_prot_base);
                `FCS_CMD_BYTE_PROG,
                `FCS_CMD_BURST_PROG: prot_hit = (addr_r >= i_prot_base);
                default: prot_hit = 1'b0;
            endcase
        end
    end

    // sequence faults: command or launch out of order, array write with full buffer,
    // unbuffered command behind a running one, program/erase before divider set
    always_comb begin
        seq_err = 1'b0;
        if (wr_arr && (!cbef_r || seq_r == FCS_SEQ_CMD)) begin
            seq_err = 1'b1;
        end else if (wr_cmd && (seq_r != FCS_SEQ_DATA || !is_legal(i_wdata))) begin
            seq_err = 1'b1;
        end else if (launch_req && (seq_r != FCS_SEQ_CMD || !cbef_r)) begin
            seq_err = 1'b1;
        end else if (launch_req && busy_r && !is_burst(cmd_r)) begin
            seq_err = 1'b1;
        end else if (launch_req && is_modify(cmd_r) && !i_div_init) begin
            seq_err = 1'b1;
        end
    end

    // a stop in the launch cycle drops the new command together with the running one
    assign launch_ok = launch_req && !seq_err && !prot_hit && !stop_abort;
    assign stop_abort = i_stop_entry && (busy_r || pend_r);
    assign transfer = pend_r && (!busy_r || i_arr_done) && !stop_abort;

    // ----------------------------------------
    // command write sequence
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            seq_r <= FCS_SEQ_IDLE;
        end else if (seq_err || launch_req) begin
            seq_r <= FCS_SEQ_IDLE;
        end else if (wr_arr) begin
            seq_r <= FCS_SEQ_DATA;
        end else if (wr_cmd) begin
            seq_r <= FCS_SEQ_CMD;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cmd_r <= `FCS_RST_CMD;
            addr_r <= `FCS_RST_ADDR;
            data_r <= `FCS_RST_DATA;
        end else begin
            if (wr_cmd && !seq_err) begin
                cmd_r <= i_wdata;
            end
            if (wr_addr_hi && !seq_err) begin
                addr_r[15:8] <= i_wdata;
            end
            if (wr_addr_lo && !seq_err) begin
                addr_r[7:0] <= i_wdata;
            end
            if (wr_data && !seq_err) begin
                data_r <= i_wdata;
            end
        end
    end

    // ----------------------------------------
    // command buffer and array engine
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pend_r <= 1'b0;
            pend_cmd_r <= `FCS_RST_CMD;
            pend_addr_r <= `FCS_RST_ADDR;
            pend_data_r <= `FCS_RST_DATA;
        end else if (stop_abort) begin
            pend_r <= 1'b0;
        end else if (launch_ok) begin
            pend_r <= 1'b1;
            pend_cmd_r <= cmd_r;
            pend_addr_r <= addr_r;
            pend_data_r <= data_r;
        end else if (transfer) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            busy_r <= 1'b0;
            busy_burst_r <= 1'b0;
            busy_blank_r <= 1'b0;
        end else if (stop_abort) begin
            busy_r <= 1'b0;
        end else if (transfer) begin
            busy_r <= 1'b1;
            busy_burst_r <= is_burst(pend_cmd_r);
            busy_blank_r <= !is_modify(pend_cmd_r);
        end else if (i_arr_done) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_arr_start <= 1'b0;
            o_arr_abort <= 1'b0;
            o_arr_cmd <= `FCS_RST_CMD;
            o_arr_addr <= `FCS_RST_ADDR;
            o_arr_data <= `FCS_RST_DATA;
        end else begin
            o_arr_start <= transfer;
            o_arr_abort <= stop_abort;
            if (transfer) begin
                o_arr_cmd <= pend_cmd_r;
                o_arr_addr <= pend_addr_r;
                o_arr_data <= pend_data_r;
            end
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // buffer empty: cleared by launch, set again when a burst leaves the buffer,
    // or when an unbuffered command finishes
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cbef_r <= 1'b1;
        end else if (stop_abort) begin
            cbef_r <= 1'b1;
        end else if (launch_ok) begin
            cbef_r <= 1'b0;
        end else if (transfer && is_burst(pend_cmd_r)) begin
            cbef_r <= 1'b1;
        end else if (i_arr_done && busy_r && !busy_burst_r && !pend_r) begin
            cbef_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ccf_r <= 1'b1;
        end else if (launch_ok) begin
            ccf_r <= 1'b0;
        end else begin
            ccf_r <= cbef_r && !busy_r && !pend_r;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pviol_r <= 1'b0;
        end else if (launch_req && !seq_err && prot_hit) begin
            pviol_r <= 1'b1;
        end else if (clr_pviol) begin
            pviol_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            accerr_r <= 1'b0;
        end else if (seq_err || stop_abort) begin
            accerr_r <= 1'b1;
        end else if (clr_accerr) begin
            accerr_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            blank_r <= 1'b0;
        end else if (launch_ok) begin
            blank_r <= 1'b0;
        end else if (i_arr_done && busy_r && busy_blank_r) begin
            blank_r <= i_arr_blank;
        end
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    fcs_irq_t irq_evt;
    logic rd_irq;

    assign irq_evt[`FCS_IRQ_CCF] = !ccf_r && !launch_ok && cbef_r && !busy_r && !pend_r;
    assign irq_evt[`FCS_IRQ_PVIOL] = launch_req && !seq_err && prot_hit;
    assign irq_evt[`FCS_IRQ_ACCERR] = seq_err || stop_abort;
    assign rd_irq = i_rd && (i_addr == `FCS_OFS_IRQ_STAT);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            irq_stat_r <= 3'h0;
        end else if (rd_irq) begin
            irq_stat_r <= irq_evt;
        end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            irq_mask_r <= `FCS_RST_IRQ_MASK;
        end else if (i_wr && i_addr == `FCS_OFS_IRQ_MASK) begin
            irq_mask_r <= i_wdata[2:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_mask_r & (rd_irq ? irq_evt : (irq_stat_r | irq_evt)));
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                `FCS_OFS_STATUS: o_rdata <= status_byte(cbef_r, ccf_r, pviol_r, accerr_r,
                    blank_r);
                `FCS_OFS_COMMAND: o_rdata <= cmd_r;
                `FCS_OFS_ADDR_HI: o_rdata <= addr_r[15:8];
                `FCS_OFS_ADDR_LO: o_rdata <= addr_r[7:0];
                `FCS_OFS_DATA: o_rdata <= data_r;
                `FCS_OFS_IRQ_STAT: o_rdata <= {5'h00, irq_stat_r};
                `FCS_OFS_IRQ_MASK: o_rdata <= {5'h00, irq_mask_r};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

/* File: sim/fcs_unit_props.sv */
// checker of the flash command unit ports
`include "fcs_cfg.svh"
`default_nettype none
module fcs_unit_props (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire fcs_pkg::fcs_byte_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire fcs_pkg::fcs_byte_t o_rdata,
    input wire logic i_div_init,
    input wire logic i_prot_en,
    input wire fcs_pkg::fcs_addr_t i_prot_base,
    input wire logic i_stop_entry,
    input wire logic i_arr_done,
    input wire logic i_arr_blank,
    input wire logic o_arr_start,
    input wire fcs_pkg::fcs_byte_t o_arr_cmd,
    input wire fcs_pkg::fcs_addr_t o_arr_addr,
    input wire fcs_pkg::fcs_byte_t o_arr_data,
    input wire logic o_arr_abort,
    input wire logic o_irq
);
    import fcs_pkg::*;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_stat_rd;
        i_rd && i_addr == `FCS_OFS_STATUS ##1 1'b1;
    endsequence
    sequence s_launch_rd;
        i_wr && i_addr == `FCS_OFS_STATUS && i_wdata[7] ##1 s_stat_rd;
    endsequence
    property p_resv_zero;
        s_stat_rd |-> !o_rdata[3] && !o_rdata[1] && !o_rdata[0];
    endproperty
    property p_launch_busy;
        s_launch_rd |-> o_rdata[4] || o_rdata[5] || (!o_rdata[6] && !o_rdata[2]);
    endproperty
    property p_start_pulse;
        o_arr_start |=> !o_arr_start;
    endproperty
    property p_legal_cmd;
        o_arr_start |-> o_arr_cmd inside {`FCS_CMD_BLANK, `FCS_CMD_BYTE_PROG,
            `FCS_CMD_BURST_PROG, `FCS_CMD_PAGE_ERASE, `FCS_CMD_FULL_ERASE};
    endproperty
    property p_prot_full;
        o_arr_start && o_arr_cmd == `FCS_CMD_FULL_ERASE |-> !$past(i_prot_en);
    endproperty
    property p_prot_prog;
        o_arr_start && o_arr_cmd inside {`FCS_CMD_BYTE_PROG, `FCS_CMD_BURST_PROG}
            && $past(i_prot_en) |-> o_arr_addr < $past(i_prot_base);
    endproperty
    property p_div_init;
        o_arr_start && o_arr_cmd != `FCS_CMD_BLANK |-> $past(i_div_init);
    endproperty
    property p_abort_cause;
        o_arr_abort |-> $past(i_stop_entry);
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved status bit read as one");
    a_launch_busy: assert property (p_launch_busy)
        else $error("launch left complete or blank flag set");
    a_start_pulse: assert property (p_start_pulse)
        else $error("array start longer than one cycle");
    a_legal_cmd: assert property (p_legal_cmd)
        else $error("undefined code handed to array");
    a_prot_full: assert property (p_prot_full)
        else $error("full erase started while protected");
    a_prot_prog: assert property (p_prot_prog)
        else $error("program started in protected range");
    a_div_init: assert property (p_div_init)
        else $error("operation started before divider set");
    a_abort_cause: assert property (p_abort_cause)
        else $error("abort without stop entry");
endmodule
bind fcs_unit fcs_unit_props u_props (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_div_init(i_div_init), .i_prot_en(i_prot_en), .i_prot_base(i_prot_base),
    .i_stop_entry(i_stop_entry), .i_arr_done(i_arr_done), .i_arr_blank(i_arr_blank),
    .o_arr_start(o_arr_start), .o_arr_cmd(o_arr_cmd), .o_arr_addr(o_arr_addr),
    .o_arr_data(o_arr_data), .o_arr_abort(o_arr_abort), .o_irq(o_irq));
`default_nettype wire

/* File: sim/fcs_unit_test.sv */
// self-checking bench of the flash command unit
`include "fcs_cfg.svh"
`default_nettype none
module fcs_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fcs_pkg::*;
    logic i_clk_sys, i_rst_n, i_wr, i_rd, i_div_init, i_prot_en, i_stop_entry;
    logic i_arr_done, i_arr_blank, o_arr_start, o_arr_abort, o_irq;
    logic [7:0] i_addr;
    fcs_byte_t i_wdata, o_rdata, o_arr_cmd, o_arr_data;
    fcs_addr_t i_prot_base, o_arr_addr;
    logic [31:0] last;
    int errors = 0, comparisons = 0, n_start = 0, n_abort = 0, k = 0;
    fcs_byte_t codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    fcs_unit uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_div_init(i_div_init), .i_prot_en(i_prot_en), .i_prot_base(i_prot_base),
        .i_stop_entry(i_stop_entry), .i_arr_done(i_arr_done), .i_arr_blank(i_arr_blank),
        .o_arr_start(o_arr_start), .o_arr_cmd(o_arr_cmd), .o_arr_addr(o_arr_addr),
        .o_arr_data(o_arr_data), .o_arr_abort(o_arr_abort), .o_irq(o_irq));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        if (o_arr_start === 1'b1) begin
            n_start <= n_start + 1;
            last <= {o_arr_cmd, o_arr_addr, o_arr_data};
        end
        if (o_arr_abort === 1'b1) n_abort <= n_abort + 1;
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
            errors++;
        end
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            i_wr <= 1'b0;
            i_rd <= 1'b0;
            i_arr_done <= 1'b0;
            i_stop_entry <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input fcs_byte_t d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
    endtask
    task automatic rd(input logic [7:0] a, input fcs_byte_t exp);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk("read data", {24'h0, o_rdata}, {24'h0, exp});
    endtask
    task automatic wait_for(ref int cnt, input int n);
        for (int i = 0; i < 10 && cnt < n; i++) step(1);
        if (cnt < n) begin
            errors++;
            end_sim();
        end
    endtask
    task automatic seq(input fcs_byte_t c, input fcs_addr_t a, input fcs_byte_t d);
        wr(`FCS_OFS_ADDR_HI, a[15:8]);
        wr(`FCS_OFS_ADDR_LO, a[7:0]);
        wr(`FCS_OFS_DATA, d);
        wr(`FCS_OFS_COMMAND, c);
    endtask
    task automatic done(input logic b);
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        i_arr_done <= 1'b1;
        i_arr_blank <= b;
        step(3);
    endtask
    task automatic run(input fcs_byte_t c, input fcs_addr_t a, input logic b);
        seq(c, a, a[7:0] ^ 8'h5A);
        wr(`FCS_OFS_STATUS, 8'h80);
        rd(`FCS_OFS_STATUS, 8'h00);
        k++;
        wait_for(n_start, k);
        chk("array request", last, {c, a, a[7:0] ^ 8'h5A});
        done(b);
        rd(`FCS_OFS_STATUS, b ? 8'hC4 : 8'hC0);
    endtask
    task automatic clr(input fcs_byte_t v);
        wr(`FCS_OFS_STATUS, v);
        rd(`FCS_OFS_STATUS, 8'hC0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {i_rst_n, i_wr, i_rd, i_prot_en, i_stop_entry, i_arr_done, i_arr_blank} = '0;
        {i_addr, i_wdata} = '0;
        i_div_init = 1'b1;
        i_prot_base = 16'h8000;
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd(`FCS_OFS_STATUS, 8'hC0);
        wr(`FCS_OFS_STATUS, 8'h0F);
        rd(`FCS_OFS_STATUS, 8'hC0);
        wr(`FCS_OFS_IRQ_MASK, 8'h04);
        seq(8'h33, 16'h0010, 8'h01);
        step(3);
        chk("irq", {31'h0, o_irq}, 32'h1);
        rd(`FCS_OFS_IRQ_STAT, 8'h04);
        step(2);
        chk("irq", {31'h0, o_irq}, 32'h0);
        rd(`FCS_OFS_STATUS, 8'hD0);
        wr(`FCS_OFS_STATUS, 8'h00);
        rd(`FCS_OFS_STATUS, 8'hD0);
        clr(8'h10);
        wr(`FCS_OFS_IRQ_MASK, 8'h00);
        wr(`FCS_OFS_STATUS, 8'h80);
        step(2);
        rd(`FCS_OFS_STATUS, 8'hD0);
        clr(8'h10);
        wr(`FCS_OFS_STATUS, 8'h90);
        rd(`FCS_OFS_STATUS, 8'hD0);
        clr(8'h10);
        foreach (codes[i]) begin
            run(codes[i], 16'h0200 + 16'(i), codes[i] == `FCS_CMD_BLANK);
            if (codes[i] == `FCS_CMD_BLANK) begin
                wr(`FCS_OFS_STATUS, 8'h04);
                rd(`FCS_OFS_STATUS, 8'hC4);
            end
        end
        seq(`FCS_CMD_BURST_PROG, 16'h0300, 8'h11);
        wr(`FCS_OFS_STATUS, 8'h80);
        k++;
        wait_for(n_start, k);
        seq(`FCS_CMD_BURST_PROG, 16'h0301, 8'h22);
        wr(`FCS_OFS_STATUS, 8'h80);
        rd(`FCS_OFS_STATUS, 8'h00);
        done(1'b0);
        k++;
        wait_for(n_start, k);
        chk("queued burst", last, {`FCS_CMD_BURST_PROG, 16'h0301, 8'h22});
        done(1'b0);
        rd(`FCS_OFS_STATUS, 8'hC0);
        i_div_init <= 1'b0;
        seq(`FCS_CMD_BYTE_PROG, 16'h0400, 8'h33);
        wr(`FCS_OFS_STATUS, 8'h80);
        step(3);
        rd(`FCS_OFS_STATUS, 8'hD0);
        clr(8'h10);
        i_div_init <= 1'b1;
        i_prot_en <= 1'b1;
        seq(`FCS_CMD_BYTE_PROG, 16'h9000, 8'h44);
        wr(`FCS_OFS_STATUS, 8'h80);
        step(3);
        rd(`FCS_OFS_STATUS, 8'hE0);
        wr(`FCS_OFS_STATUS, 8'h00);
        rd(`FCS_OFS_STATUS, 8'hE0);
        clr(8'h20);
        seq(`FCS_CMD_FULL_ERASE, 16'h0000, 8'h00);
        wr(`FCS_OFS_STATUS, 8'h80);
        rd(`FCS_OFS_STATUS, 8'hE0);
        clr(8'h20);
        run(`FCS_CMD_BYTE_PROG, 16'h1000, 1'b0);
        i_prot_en <= 1'b0;
        seq(`FCS_CMD_BYTE_PROG, 16'h0500, 8'h66);
        wr(`FCS_OFS_STATUS, 8'h80);
        k++;
        wait_for(n_start, k);
        @(posedge i_clk_sys);
        i_stop_entry <= 1'b1;
        wait_for(n_abort, 1);
        step(3);
        rd(`FCS_OFS_STATUS, 8'hD0);
        clr(8'h10);
        rd(`FCS_OFS_IRQ_STAT, 8'h07);
        rd(`FCS_OFS_IRQ_STAT, 8'h00);
        rd(8'h07, 8'h00);
        chk("irq", {31'h0, o_irq}, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
